// file: rtl/lcdpm_top.v
// Top of the LCD pixel map and waveform generator: register file on an
// Avalon-MM slave, enable and shutdown sequencing, interrupts and pins.
// Assumes slow LCD clocks arrive as one-cycle ticks on core_clk_i and
// that sleep_i is a synchronous level from the power controller.
//
// Operation
// RULE1: Pixel for column n, common c is pixel register 3c+n/8, bit n%8.
// RULE2: Each pixel sees zero DC and a dark or clear RMS level.
// RULE3: Backplanes mark their common slot; columns carry that slot's data.
// RULE4: Type-A inverts drive phase inside every common slot.
// RULE5: Type-B inverts drive phase only at frame boundaries.
// RULE6: With the system clock/256 source, sleep stops the module at once.
// RULE7: Software sleeps with stop-in-sleep only when pixel DC is zero.
// RULE8: Interrupt when the module goes from active to inactive.
// RULE9: Frame interrupt marks frame boundaries in Type-B drive.
// RULE10: Waveform select clear gives Type-A, set gives Type-B.
// RULE11: No frame interrupt in Type-A or in static Type-B.
// RULE12: Pixel write while writes are closed in Type-B: flag, discard.
// RULE13: Enable cleared: finish frame, clear active, raise shutdown irq.
// RULE14: Slots per frame follow multiplex; Type-B polarity toggles per frame.
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "lcdpm_defines.vh"

module lcdpm_top (
  input wire core_clk_i,
  input wire rstn_i,
  // Avalon-MM slave
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // Slow LCD clock ticks and power state
  input wire slow_tick_a_i,
  input wire slow_tick_b_i,
  input wire sleep_i,
  // Panel pins and interrupt
  output wire [7:0] backplane_drive_o,
  output wire [47:0] pixel_column_drive_o,
  output reg irq_o
);

  // =====================================================================
  // Declarations
  reg [7:0] pix_q [0:11];
  reg [11:0] ctrl_q;
  reg active_q;
  reg pol_q;
  reg wr_open_q;
  reg [2:0] ist_q;
  reg [2:0] ien_q;
  reg [7:0] div_q;
  reg [31:0] rdata_d;
  reg [2:0] ist_d;
  reg tick;

  wire [95:0] pix_flat;
  wire module_enable_bit;
  wire waveform_type_select;
  wire [1:0] multiplex_select;
  wire stop_in_sleep_select;
  wire [1:0] clk_src;
  wire [3:0] prescale;
  wire halted;
  wire run;
  wire phase;
  wire [1:0] slot;
  wire half;
  wire slot_end;
  wire frame_end;
  wire acc;
  wire wr_acc;
  wire [5:0] widx;
  wire pix_hit;
  wire wr_pix;
  wire wr_block;
  wire frame_irq;
  wire shut_evt;
  wire write_error_flag_evt;

  // Control fields
  assign module_enable_bit = ctrl_q[`LCDPM_CTRL_EN];
  assign waveform_type_select = ctrl_q[`LCDPM_CTRL_WFT];
  assign multiplex_select = ctrl_q[`LCDPM_CTRL_MUX_HI:`LCDPM_CTRL_MUX_LO];
  assign stop_in_sleep_select = ctrl_q[`LCDPM_CTRL_SLP];
  assign clk_src = ctrl_q[`LCDPM_CTRL_SRC_HI:`LCDPM_CTRL_SRC_LO];
  assign prescale = ctrl_q[`LCDPM_CTRL_PRE_HI:`LCDPM_CTRL_PRE_LO];

  // =====================================================================
  // Bus decode
  // A request is served on the edge at which waitrequest reads low, so
  // every access costs exactly one wait cycle.
  assign acc = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  assign wr_acc = avs_write_i & ~avs_waitrequest_o;
  assign widx = avs_address_i[7:2];
  assign pix_hit = (widx < `LCDPM_NUM_PIX);
  assign wr_pix = wr_acc & pix_hit;

  // RULE12: write window
  // Type-B multiplexed drive needs pixel data steady across the frame
  // pair, so writes land only in the window after a frame interrupt.
  assign wr_block = active_q & waveform_type_select &
                    (multiplex_select != 2'h0) & ~wr_open_q;
  assign write_error_flag_evt = wr_pix & wr_block;

  // Waitrequest: high at rest, low for one cycle per request
  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) &
                             avs_waitrequest_o);
  end

  // =====================================================================
  // Pixel data registers
  // RULE1: flat pixel map
  // Word k of the array sits at bits 8k, so common c, column n lands
  // at bit 24c + n of the flat vector.
  genvar g;
  generate
    for (g = 0; g < `LCDPM_NUM_PIX; g = g + 1)
    begin : g_pix
      assign pix_flat[8*g+7:8*g] = pix_q[g];

      always @(posedge core_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          pix_q[g] <= 8'h00;
        // RULE12: discard blocked
        else if (wr_pix && !wr_block && widx == g)
          pix_q[g] <= avs_writedata_i[7:0];
      end
    end
  endgenerate

  // =====================================================================
  // Control and interrupt enable registers
  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_q <= `LCDPM_CTRL_RST;
      ien_q <= 3'h0;
    end
    else if (wr_acc)
    begin
      if (avs_address_i == `LCDPM_OFF_CTRL)
        ctrl_q <= avs_writedata_i[11:0] & `LCDPM_CTRL_MASK;
      if (avs_address_i == `LCDPM_OFF_INT_EN)
        ien_q <= avs_writedata_i[2:0];
    end
  end

  // =====================================================================
  // LCD clock source
  // The /256 divider free-runs; slow sources come in as ready ticks.
  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  always @*
  begin
    case (clk_src)
      `LCDPM_SRC_DIV256: tick = (div_q == `LCDPM_DIV_LAST);
      `LCDPM_SRC_SLOW_A: tick = slow_tick_a_i;
      default: tick = slow_tick_b_i;
    endcase
  end

  // RULE6: sleep stop
  // The /256 source dies with the core clock in sleep, so that source
  // stops regardless of stop_in_sleep_select. Software must only sleep
  // when pixel DC is balanced; the block cannot fix this afterwards.
  // RULE7: relies on software
  assign halted = sleep_i &
                  (stop_in_sleep_select || clk_src == `LCDPM_SRC_DIV256);
  assign run = active_q & ~halted;

  // =====================================================================
  // Slot sequencer
  lcdpm_timing u_timing (
    .core_clk_i (core_clk_i),
    .rstn_i (rstn_i),
    .run_i (run),
    .tick_i (tick),
    .wft_i (waveform_type_select),
    .mux_i (multiplex_select),
    .pre_i (prescale),
    .slot_o (slot),
    .half_o (half),
    .slot_end_o (slot_end),
    .frame_end_o (frame_end)
  );

  // =====================================================================
  // Drive phase
  // RULE10: type select
  // RULE4: in-slot inversion
  // RULE5: per-frame inversion
  assign phase = waveform_type_select ? pol_q : half;

  // RULE14: frame polarity
  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pol_q <= 1'b0;
    else if (!active_q)
      pol_q <= 1'b0;
    else if (frame_end && waveform_type_select)
      pol_q <= ~pol_q;
  end

  // =====================================================================
  // Enable and shutdown sequencing
  // RULE13: finish frame
  // Disabling mid-frame would leave DC on the glass, so the module runs
  // to the frame boundary before it drops active.
  assign shut_evt = active_q & ~module_enable_bit & frame_end;

  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      active_q <= 1'b0;
    else if (!active_q && module_enable_bit)
      active_q <= 1'b1;
    else if (shut_evt)
      active_q <= 1'b0;
  end

  // =====================================================================
  // Frame interrupt and write window
  // RULE9: frame event
  // RULE11: suppressed cases
  assign frame_irq = frame_end & waveform_type_select &
                     (multiplex_select != 2'h0);

  // The window opens on the frame interrupt and closes at the end of
  // the first slot of the next frame.
  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wr_open_q <= 1'b0;
    else if (frame_irq)
      wr_open_q <= 1'b1;
    else if (slot_end || !active_q)
      wr_open_q <= 1'b0;
  end

  // =====================================================================
  // Interrupt status
  // A new event in the cycle of a clear keeps its bit set.
  always @*
  begin
    ist_d = ist_q;
    if (wr_acc && avs_address_i == `LCDPM_OFF_INT_CLR)
      ist_d = ist_q & ~avs_writedata_i[2:0];
    // RULE8: shutdown event
    if (shut_evt)
      ist_d[`LCDPM_IRQ_SHUT] = 1'b1;
    if (frame_irq)
      ist_d[`LCDPM_IRQ_FRAME] = 1'b1;
    // RULE12: error flag
    if (write_error_flag_evt)
      ist_d[`LCDPM_IRQ_WRITE_ERROR_FLAG] = 1'b1;
  end

  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ist_q <= 3'h0;
      irq_o <= 1'b0;
    end
    else
    begin
      ist_q <= ist_d;
      irq_o <= |(ist_d & ien_q);
    end
  end

  // =====================================================================
  // Read data
  // Captured on the cycle before the serving edge so it stands there.
  always @*
  begin
    rdata_d = 32'h0000_0000;
    if (pix_hit)
      rdata_d = {24'h000000, pix_q[widx[3:0]]};
    else
    begin
      case (avs_address_i)
        `LCDPM_OFF_CTRL: rdata_d = {20'h00000, ctrl_q};
        `LCDPM_OFF_STAT:
          rdata_d = {30'h0, ist_q[`LCDPM_IRQ_WRITE_ERROR_FLAG], active_q};
        `LCDPM_OFF_INT_STAT: rdata_d = {29'h0, ist_q};
        `LCDPM_OFF_INT_EN: rdata_d = {29'h0, ien_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && avs_waitrequest_o)
      avs_readdata_o <= rdata_d;
  end

  // =====================================================================
  // Waveform mapping and pin registers
  // RULE2: zero-DC levels
  // RULE3: slot drive
  lcdpm_drive u_drive (
    .core_clk_i (core_clk_i),
    .rstn_i (rstn_i),
    .run_i (run),
    .phase_i (phase),
    .mux_i (multiplex_select),
    .slot_i (slot),
    .pix_i (pix_flat),
    .backplane_drive_o (backplane_drive_o),
    .pixel_column_drive_o (pixel_column_drive_o)
  );

endmodule

// file: rtl/lcdpm_defines.vh
// Constants for the LCD pixel map and waveform generator.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`ifndef LCDPM_DEFINES_VH
`define LCDPM_DEFINES_VH

// =====================================================================
// Register byte offsets
`define LCDPM_OFF_PIX0 8'h00
`define LCDPM_OFF_PIX11 8'h2c
`define LCDPM_OFF_CTRL 8'h30
`define LCDPM_OFF_STAT 8'h34
`define LCDPM_OFF_INT_STAT 8'h38
`define LCDPM_OFF_INT_CLR 8'h3c
`define LCDPM_OFF_INT_EN 8'h40
`define LCDPM_NUM_PIX 12

// =====================================================================
// Control register fields
`define LCDPM_CTRL_EN 0
`define LCDPM_CTRL_WFT 1
`define LCDPM_CTRL_MUX_LO 2
`define LCDPM_CTRL_MUX_HI 3
`define LCDPM_CTRL_SLP 4
`define LCDPM_CTRL_SRC_LO 5
`define LCDPM_CTRL_SRC_HI 6
`define LCDPM_CTRL_PRE_LO 8
`define LCDPM_CTRL_PRE_HI 11
`define LCDPM_CTRL_RST 12'h000
`define LCDPM_CTRL_MASK 12'hf7f

// Clock source codes
`define LCDPM_SRC_DIV256 2'h0
`define LCDPM_SRC_SLOW_A 2'h1

// Status register fields
`define LCDPM_STAT_ACTIVE 0
`define LCDPM_STAT_WRITE_ERROR_FLAG 1

// Interrupt bits
`define LCDPM_IRQ_SHUT 0
`define LCDPM_IRQ_FRAME 1
`define LCDPM_IRQ_WRITE_ERROR_FLAG 2

// Divider terminal count for the system clock / 256 source
`define LCDPM_DIV_LAST 8'hff

// =====================================================================
// Drive levels on a 1/3 bias ladder, V0 lowest
`define LCDPM_V0 2'h0
`define LCDPM_V1 2'h1
`define LCDPM_V2 2'h2
`define LCDPM_V3 2'h3

`endif

// file: rtl/lcdpm_timing.v
// Slot and frame sequencer for the LCD waveform generator.
// Assumes tick_i is a one-cycle pulse of the selected slow LCD clock.
`timescale 1ns/1ps
`include "lcdpm_defines.vh"

module lcdpm_timing (
  input wire core_clk_i,
  input wire rstn_i,
  input wire run_i,
  input wire tick_i,
  input wire wft_i,
  input wire [1:0] mux_i,
  input wire [3:0] pre_i,
  output wire [1:0] slot_o,
  output wire half_o,
  output wire slot_end_o,
  output wire frame_end_o
);

  reg [3:0] cnt_q;
  reg half_q;
  reg [1:0] slot_q;
  wire step_end;

  // Each step lasts prescale + 1 ticks of the LCD clock
  assign step_end = run_i & tick_i & (cnt_q == pre_i);
  // Type-A slots hold two phase halves, Type-B slots only one
  assign slot_end_o = step_end & (wft_i | half_q);
  assign frame_end_o = slot_end_o & (slot_q == mux_i);
  assign slot_o = slot_q;
  assign half_o = half_q;

  // =====================================================================
  // Counters; cleared while stopped so a restart begins at common 0
  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_q <= 4'h0;
      half_q <= 1'b0;
      slot_q <= 2'h0;
    end
    else if (!run_i)
    begin
      cnt_q <= 4'h0;
      half_q <= 1'b0;
      slot_q <= 2'h0;
    end
    else if (tick_i)
    begin
      cnt_q <= step_end ? 4'h0 : cnt_q + 4'h1;
      if (step_end)
        half_q <= wft_i ? 1'b0 : ~half_q;
      // RULE14: slot count
      if (frame_end_o)
        slot_q <= 2'h0;
      else if (slot_end_o)
        slot_q <= slot_q + 2'h1;
    end
  end

endmodule

// file: rtl/lcdpm_drive.v
// Maps pixel bits onto backplane and column drive levels.
// Assumes levels are codes for a 1/3 bias ladder outside this block.
`timescale 1ns/1ps
`include "lcdpm_defines.vh"

module lcdpm_drive (
  input wire core_clk_i,
  input wire rstn_i,
  input wire run_i,
  input wire phase_i,
  input wire [1:0] mux_i,
  input wire [1:0] slot_i,
  input wire [95:0] pix_i,
  output reg [7:0] backplane_drive_o,
  output reg [47:0] pixel_column_drive_o
);

  reg [23:0] row;
  wire [7:0] com_d;
  wire [47:0] seg_d;
  wire stat;

  assign stat = (mux_i == 2'h0);

  // RULE1: row pick
  always @*
  begin
    case (slot_i)
      2'h0: row = pix_i[23:0];
      2'h1: row = pix_i[47:24];
      2'h2: row = pix_i[71:48];
      2'h3: row = pix_i[95:72];
      default: row = 24'h000000;
    endcase
  end

  // =====================================================================
  // Levels per common and per column
  genvar g;
  generate
    for (g = 0; g < 24; g = g + 1)
    begin : g_lvl
      // RULE2: two RMS levels
      assign seg_d[2*g+1:2*g] = stat ?
        ((row[g] ^ phase_i) ? `LCDPM_V0 : `LCDPM_V3) :
        (row[g] ? (phase_i ? `LCDPM_V3 : `LCDPM_V0) :
                  (phase_i ? `LCDPM_V1 : `LCDPM_V2));
      if (g < 4)
      begin : g_com
        // RULE3: backplane slot mark
        assign com_d[2*g+1:2*g] = (g > mux_i) ? `LCDPM_V0 :
          stat ? (phase_i ? `LCDPM_V3 : `LCDPM_V0) :
          (slot_i == g) ? (phase_i ? `LCDPM_V0 : `LCDPM_V3) :
                          (phase_i ? `LCDPM_V2 : `LCDPM_V1);
      end
    end
  endgenerate

  // Registered pins; stopped module drives the lowest level
  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      backplane_drive_o <= 8'h00;
      pixel_column_drive_o <= 48'h0;
    end
    else
    begin
      backplane_drive_o <= run_i ? com_d : 8'h00;
      pixel_column_drive_o <= run_i ? seg_d : 48'h0;
    end
  end

endmodule

// file: verification/lcdpm_asserts.sv
// Checker for lcdpm_top: bus handshake and drive waveform relations.
// Sees only the top ports; keeps its own copy of the control word.
`timescale 1ns/1ps
module lcdpm_asserts (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire slow_tick_a_i,
  input wire slow_tick_b_i,
  input wire sleep_i,
  input wire [7:0] backplane_drive_o,
  input wire [47:0] pixel_column_drive_o,
  input wire irq_o
);
  reg [11:0] ctrl_q;
  reg [2:0] sel_n;
  integer i;
  wire [7:0] bp = backplane_drive_o;
  wire [1:0] com0 = backplane_drive_o[1:0];
  wire [1:0] mux = ctrl_q[3:2];
  wire type_b = ctrl_q[1];

  // ===================================================================
  // Helpers
  // Control copy, taken only when a write really completes
  always @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i)
      ctrl_q <= 12'h000;
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h30)
      ctrl_q <= avs_writedata_i[11:0];

  // Commons on an outer level are the selected one this half
  always @*
  begin
    sel_n = 3'h0;
    for (i = 0; i < 4; i = i + 1)
      if (bp[2*i+:2] == 2'h0 || bp[2*i+:2] == 2'h3)
        sel_n = sel_n + 3'h1;
  end

  // ===================================================================
  // Properties
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  wait_low_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one wait");
  wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  sleep_stop_a: assert property (
    $rose(sleep_i) && ctrl_q[6:5] == 2'h0 |-> ##[1:2]
    (bp == 8'h00 && pixel_column_drive_o == 48'h0))
    else $error("pins not stopped by sleep");
  type_a_inv_a: assert property (
    $fell(com0 == 2'h3) && !type_b && mux != 2'h0 && !sleep_i
    |-> com0 == 2'h0)
    else $error("no phase inversion inside slot");
  type_b_hold_a: assert property (
    $fell(com0 == 2'h3) && type_b && mux != 2'h0 && !sleep_i
    |-> com0 == 2'h1 || com0 == 2'h2)
    else $error("phase inverted inside frame");
  static_com_a: assert property (
    mux == 2'h0 |-> bp[7:2] == 6'h00)
    else $error("unused common driven in static mode");
  one_slot_a: assert property (
    mux == 2'h3 && bp != 8'h00 |-> sel_n == 3'h1)
    else $error("not exactly one common selected");
  col_pair_a: assert property (
    mux != 2'h0 && com0 == 2'h3
    |-> (pixel_column_drive_o & {24{2'h1}}) == 48'h0)
    else $error("column level not paired with backplane");
endmodule

bind lcdpm_top lcdpm_asserts lcdpm_asserts_inst (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .slow_tick_a_i(slow_tick_a_i), .slow_tick_b_i(slow_tick_b_i),
  .sleep_i(sleep_i), .backplane_drive_o(backplane_drive_o),
  .pixel_column_drive_o(pixel_column_drive_o), .irq_o(irq_o));

// file: verification/lcdpm_panel.sv
// Passive glass model: integrates what each pixel sees.
// Assumes level codes 0..3 on backplane and column pins.
`timescale 1ns/1ps
module lcdpm_panel (
  input wire core_clk_i,
  input wire clear_i,
  input wire [7:0] backplane_drive_i,
  input wire [47:0] pixel_column_drive_i
);
  integer dc [0:95];
  integer sq [0:95];
  integer c, n, d;
  // Pixel voltage is backplane minus column; sum gives DC, squares RMS
  always @(posedge core_clk_i)
    for (c = 0; c < 4; c = c + 1)
      for (n = 0; n < 24; n = n + 1)
      begin
        d = backplane_drive_i[2*c+:2] - pixel_column_drive_i[2*n+:2];
        dc[24*c+n] = clear_i ? 0 : dc[24*c+n] + d;
        sq[24*c+n] = clear_i ? 0 : sq[24*c+n] + d * d;
      end
endmodule

// file: verification/lcdpm_top_tb.sv
// Testbench for lcdpm_top: Avalon tasks, column monitor, scenarios.
// Assumes slow ticks on every cycle so frames stay short.
`timescale 1ns/1ps
module lcdpm_top_tb;
  reg core_clk_i, rstn_i, rd, wr, sleep, clr, mon;
  reg [7:0] addr;
  reg [31:0] wdata, q;
  reg [7:0] pix [0:11];
  reg [1:0] lv, ex;
  wire [31:0] rdata;
  wire wait_q, irq;
  wire [7:0] bp;
  wire [47:0] col;
  integer n_fail, checks, cyc, k, mc, mk;

  lcdpm_top lcdpm_top_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_q), .slow_tick_a_i(1'b1),
    .slow_tick_b_i(1'b1), .sleep_i(sleep), .backplane_drive_o(bp),
    .pixel_column_drive_o(col), .irq_o(irq));
  lcdpm_panel lcdpm_panel_inst (.core_clk_i(core_clk_i), .clear_i(clr),
    .backplane_drive_i(bp), .pixel_column_drive_i(col));

  // ===================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  end
  endtask

  // Request held until waitrequest is sampled low; the timeout bounds it
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge core_clk_i);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    // Look just after each edge, where waitrequest has settled; the
    // edge after it is seen low is the one that serves the request
    do
    begin
      @(posedge core_clk_i);
      #1;
    end
    while (wait_q !== 1'b0);
    @(posedge core_clk_i);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  end
  endtask

  task wrr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
  begin
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  end
  endtask

  task wait_irq;
    while (irq !== 1'b1)
      @(posedge core_clk_i);
  endtask

  task complete_run;
  begin
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  // ===================================================================
  // Clock, timeout and column monitor
  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  // A hang counts as a failure rather than a silent stall
  always @(posedge core_clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end

  // Columns must carry the selected common's bits, dark opposite it
  always @(posedge core_clk_i)
    if (mon && bp != 8'h00)
      for (mc = 0; mc < 4; mc = mc + 1)
      begin
        lv = bp[2*mc+:2];
        if (lv == 2'h3 || lv == 2'h0)
          for (mk = 0; mk < 24; mk = mk + 1)
          begin
            ex = pix[3*mc+mk/8][mk%8] ? 2'h3 - lv : (lv[0] ? 2'h2 : 2'h1);
            chk("column", {30'h0, ex}, {30'h0, col[2*mk+:2]});
          end
      end

  // ===================================================================
  // Scenarios
  initial
  begin
    n_fail = 0;
    checks = 0;
    cyc = 0;
    rstn_i = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    sleep = 1'b0;
    clr = 1'b1;
    mon = 1'b0;
    repeat (8) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    clr <= 1'b0;
    // Reset values and an unmapped read
    rc("ctrl", 8'h30, 32'h0);
    rc("status", 8'h34, 32'h0);
    rc("int_stat", 8'h38, 32'h0);
    rc("unmapped", 8'h44, 32'h0);
    // Pixel registers are plain storage while the module is off
    for (k = 0; k < 12; k = k + 1)
    begin
      pix[k] = 8'h5a ^ k[7:0];
      wrr({k[5:0], 2'b00}, {24'h0, pix[k]});
    end
    for (k = 0; k < 12; k = k + 1)
    begin
      bus(1'b0, {k[5:0], 2'b00}, 32'h0);
      chk("pixel", {24'h0, pix[k]}, {24'h0, q[7:0]});
    end
    // Type-A, quarter multiplex, then shutdown at frame end
    wrr(8'h40, 32'h3);
    mon = 1'b1;
    wrr(8'h30, 32'h2d);
    repeat (200) @(posedge core_clk_i);
    rc("status", 8'h34, 32'h1);
    rc("int_stat", 8'h38, 32'h0);
    wrr(8'h30, 32'h2c);
    wait_irq;
    mon = 1'b0;
    rc("status", 8'h34, 32'h0);
    rc("int_stat", 8'h38, 32'h1);
    chk("pins", 32'h0, {31'h0, |{bp, col}});
    for (k = 0; k < 96; k = k + 1)
      chk("dc", 32'h0, lcdpm_panel_inst.dc[k]);
    chk("rms", 32'h1, {31'h0, lcdpm_panel_inst.sq[1] > lcdpm_panel_inst.sq[0]});
    wrr(8'h3c, 32'h7);
    rc("int_stat", 8'h38, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    // Type-B: write inside the frame window, then outside it
    wrr(8'h40, 32'h2);
    wrr(8'h30, 32'hf2f);
    wait_irq;
    wrr(8'h00, 32'ha5);
    rc("int_stat", 8'h38, 32'h2);
    wrr(8'h3c, 32'h2);
    repeat (30) @(posedge core_clk_i);
    wrr(8'h00, 32'h3c);
    bus(1'b0, 8'h00, 32'h0);
    chk("kept", 32'ha5, {24'h0, q[7:0]});
    rc("status", 8'h34, 32'h3);
    bus(1'b0, 8'h38, 32'h0);
    chk("write_error_flag_int", 32'h1, {31'h0, q[2]});
    wrr(8'h3c, 32'h7);
    wrr(8'h40, 32'h1);
    wrr(8'h30, 32'hf2e);
    wait_irq;
    bus(1'b0, 8'h38, 32'h0);
    chk("shut_b", 32'h1, {31'h0, q[0]});
    wrr(8'h3c, 32'h7);
    // Static Type-B gives no frame interrupt
    wrr(8'h40, 32'h2);
    wrr(8'h30, 32'h23);
    repeat (200) @(posedge core_clk_i);
    rc("int_stat", 8'h38, 32'h0);
    wrr(8'h40, 32'h1);
    wrr(8'h30, 32'h32);
    wait_irq;
    // Sleep with stop selected, only once the glass is idle
    sleep <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk("idle_pins", 32'h0, {31'h0, |{bp, col}});
    sleep <= 1'b0;
    wrr(8'h3c, 32'h7);
    // System clock/256 source stops at once on sleep
    wrr(8'h30, 32'h0d);
    while (bp === 8'h00)
      @(posedge core_clk_i);
    sleep <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk("sleep_pins", 32'h0, {31'h0, |{bp, col}});
    repeat (300) @(posedge core_clk_i);
    chk("frozen_pins", 32'h0, {31'h0, |{bp, col}});
    complete_run;
  end
endmodule
